//--- rtl/bas_blit_addr.sv
// Notes on behaviour
// R1: Pattern fill needs width above 2/1 pixels.
// R2: Source start is 21 bits over three bytes.
// R3: Host-sourced data uses only source bit 0.
// R4: Pattern source is base plus line plus pixel.
// R5: 8 bpp fields: 20:6, 5:3, 2:0.
// R6: 16 bpp fields: 20:7, 6:4, 3:0.
// R7: Destination start is 21 bits over three bytes.
// R8: Keep 11-bit line to line word offset.
// R9: Offset used only for rectangular regions.
// R10: Width is 10 bits over two registers.
// R11: Pixel width equals stored width plus one.
// R12: Source linear bit selects contiguous or rectangular.
// R13: Colour format bit: one 16 bpp, zero 8.
// R14: Next line start adds offset to previous.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bas_blit_addr
    import bas_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic [bas_pkg::BAS_AW-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Unused protection
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [bas_pkg::BAS_AW-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Unused protection
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic line_load, // Engine pulse: restart at start
    input wire logic line_next, // Engine pulse: step to next line
    output bas_pkg::bas_geom_t geom // Registered address geometry
);
    import bas_pkg::*;

    bas_state_t st_q;
    bas_state_t st_d;
    logic wr_fire;
    logic wr_hit;
    logic [BAS_IW-1:0] wr_idx;
    logic load_ev;
    logic next_ev;
    logic [20:0] off_bytes;

    function automatic logic [BAS_IW-1:0] reg_idx(
        input logic [BAS_AW-1:0] a
    );
        return a[BAS_AW-1:2];
    endfunction : reg_idx

    function automatic logic reg_hit(input logic [BAS_IW-1:0] i);
        logic h;
        h = 1'h0;
        case (i)
            BAS_IDX_SRC_LO, BAS_IDX_SRC_MID, BAS_IDX_SRC_HI,
            BAS_IDX_DST_LO, BAS_IDX_DST_MID, BAS_IDX_DST_HI,
            BAS_IDX_OFF_LO, BAS_IDX_OFF_HI,
            BAS_IDX_WID_LO, BAS_IDX_WID_HI,
            BAS_IDX_CTRL, BAS_IDX_CMD,
            BAS_IDX_SRC_LINE, BAS_IDX_DST_LINE, BAS_IDX_WID_PIX: h = 1'h1;
            default: h = 1'h0;
        endcase
        return h;
    endfunction : reg_hit

    // Step the pattern line field, wrapping within the pattern
    function automatic logic [20:0] pat_step(
        input logic [20:0] a,
        input logic bpp16
    );
        logic [20:0] r;
        r = a;
        if (bpp16) begin
            r[BAS_P16_LINE_LSB +: 3] = a[BAS_P16_LINE_LSB +: 3] + 3'h1;
        end else begin
            r[BAS_P8_LINE_LSB +: 3] = a[BAS_P8_LINE_LSB +: 3] + 3'h1;
        end
        return r;
    endfunction : pat_step

    assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
    assign s_axi_wready = !st_q.w_held && !st_q.bvalid;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign geom = st_q.geom;

    assign wr_fire = st_q.aw_held && st_q.w_held;
    assign wr_idx = reg_idx(st_q.awaddr);
    assign wr_hit = reg_hit(wr_idx);
    // Offset counts 16-bit words; line addresses count bytes
    assign off_bytes = {9'h0, st_q.regs.line_off, 1'h0};
    assign load_ev = line_load
        || (wr_fire && st_q.wstrb0 && wr_idx == BAS_IDX_CMD
            && st_q.wdata[BAS_CMD_LOAD]);
    assign next_ev = line_next
        || (wr_fire && st_q.wstrb0 && wr_idx == BAS_IDX_CMD
            && st_q.wdata[BAS_CMD_NEXT]);

    always_comb begin
        st_d = st_q;
        // Write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_held = 1'h1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_held = 1'h1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb0 = s_axi_wstrb[0];
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'h0;
        end
        if (wr_fire) begin
            st_d.aw_held = 1'h0;
            st_d.w_held = 1'h0;
            st_d.bvalid = 1'h1;
            st_d.bresp = wr_hit ? BAS_RESP_OKAY : BAS_RESP_SLVERR;
            if (st_q.wstrb0) begin
                case (wr_idx)
                    BAS_IDX_SRC_LO: st_d.regs.src_addr[7:0] =
                        st_q.wdata[7:0]; // [R2]
                    BAS_IDX_SRC_MID: st_d.regs.src_addr[15:8] =
                        st_q.wdata[7:0]; // [R2]
                    BAS_IDX_SRC_HI: st_d.regs.src_addr[20:16] =
                        st_q.wdata[4:0]; // [R2]
                    BAS_IDX_DST_LO: st_d.regs.dst_addr[7:0] =
                        st_q.wdata[7:0]; // [R7]
                    BAS_IDX_DST_MID: st_d.regs.dst_addr[15:8] =
                        st_q.wdata[7:0]; // [R7]
                    BAS_IDX_DST_HI: st_d.regs.dst_addr[20:16] =
                        st_q.wdata[4:0]; // [R7]
                    BAS_IDX_OFF_LO: st_d.regs.line_off[7:0] =
                        st_q.wdata[7:0]; // [R8]
                    BAS_IDX_OFF_HI: st_d.regs.line_off[10:8] =
                        st_q.wdata[2:0]; // [R8]
                    BAS_IDX_WID_LO: st_d.regs.width[7:0] =
                        st_q.wdata[7:0]; // [R10]
                    BAS_IDX_WID_HI: st_d.regs.width[9:8] =
                        st_q.wdata[1:0]; // [R10]
                    BAS_IDX_CTRL: begin
                        st_d.regs.bpp16 = st_q.wdata[BAS_CTRL_BPP16];
                        st_d.regs.src_linear =
                            st_q.wdata[BAS_CTRL_SRC_LIN];
                        st_d.regs.dst_linear =
                            st_q.wdata[BAS_CTRL_DST_LIN];
                        st_d.regs.src_host = st_q.wdata[BAS_CTRL_SRC_HOST];
                        st_d.regs.pat_fill = st_q.wdata[BAS_CTRL_PAT_FILL];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Register read port
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'h0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'h1;
            st_d.rdata = 32'h0;
            st_d.rresp = reg_hit(reg_idx(s_axi_araddr)) ?
                BAS_RESP_OKAY : BAS_RESP_SLVERR;
            case (reg_idx(s_axi_araddr))
                BAS_IDX_SRC_LO: st_d.rdata[7:0] = st_q.regs.src_addr[7:0];
                BAS_IDX_SRC_MID: st_d.rdata[7:0] = st_q.regs.src_addr[15:8];
                BAS_IDX_SRC_HI: st_d.rdata[4:0] =
                    st_q.regs.src_addr[20:16];
                BAS_IDX_DST_LO: st_d.rdata[7:0] = st_q.regs.dst_addr[7:0];
                BAS_IDX_DST_MID: st_d.rdata[7:0] = st_q.regs.dst_addr[15:8];
                BAS_IDX_DST_HI: st_d.rdata[4:0] =
                    st_q.regs.dst_addr[20:16];
                BAS_IDX_OFF_LO: st_d.rdata[7:0] = st_q.regs.line_off[7:0];
                BAS_IDX_OFF_HI: st_d.rdata[2:0] = st_q.regs.line_off[10:8];
                BAS_IDX_WID_LO: st_d.rdata[7:0] = st_q.regs.width[7:0];
                BAS_IDX_WID_HI: st_d.rdata[1:0] = st_q.regs.width[9:8];
                BAS_IDX_CTRL: begin
                    st_d.rdata[BAS_CTRL_BPP16] = st_q.regs.bpp16;
                    st_d.rdata[BAS_CTRL_SRC_LIN] = st_q.regs.src_linear;
                    st_d.rdata[BAS_CTRL_DST_LIN] = st_q.regs.dst_linear;
                    st_d.rdata[BAS_CTRL_SRC_HOST] = st_q.regs.src_host;
                    st_d.rdata[BAS_CTRL_PAT_FILL] = st_q.regs.pat_fill;
                end
                BAS_IDX_SRC_LINE: st_d.rdata[20:0] = st_q.src_line;
                BAS_IDX_DST_LINE: st_d.rdata[20:0] = st_q.dst_line;
                BAS_IDX_WID_PIX: st_d.rdata[10:0] = st_q.geom.width_pix;
                default: st_d.rdata = 32'h0;
            endcase
        end

        // Line start generation; a load wins over a step
        if (load_ev) begin
            st_d.src_line = st_q.regs.src_addr; // [R14]
            st_d.dst_line = st_q.regs.dst_addr; // [R14]
        end else if (next_ev) begin
            if (st_q.regs.src_host) begin
                st_d.src_line = st_q.src_line;
            end else if (st_q.regs.pat_fill) begin
                st_d.src_line = pat_step(st_q.src_line, st_q.regs.bpp16);
            end else if (!st_q.regs.src_linear) begin
                st_d.src_line = st_q.src_line + off_bytes; // [R9] [R12]
            end
            if (!st_q.regs.dst_linear) begin
                st_d.dst_line = st_q.dst_line + off_bytes; // [R14]
            end
        end

        // Geometry handed to the engine
        st_d.geom.bpp16 = st_q.regs.bpp16; // [R13]
        st_d.geom.width_pix = {1'h0, st_q.regs.width} + 11'h1; // [R11]
        st_d.geom.dst_line = st_q.dst_line;
        st_d.geom.host_byte_sel = st_q.src_line[0]; // [R3]
        if (st_q.regs.src_host) begin
            st_d.geom.src_line = {20'h0, st_q.src_line[0]}; // [R3]
        end else begin
            st_d.geom.src_line = st_q.src_line;
        end
        st_d.geom.pat_base = 15'h0;
        st_d.geom.pat_line = 3'h0;
        st_d.geom.pix_off = 4'h0;
        if (st_q.regs.pat_fill && !st_q.regs.src_host) begin
            if (st_q.regs.bpp16) begin
                st_d.geom.pat_base = {1'h0,
                    st_q.src_line[20:BAS_P16_BASE_LSB]}; // [R6]
                st_d.geom.pat_line =
                    st_q.src_line[BAS_P16_LINE_LSB +: 3]; // [R6]
                st_d.geom.pix_off = st_q.src_line[3:0]; // [R6]
            end else begin
                st_d.geom.pat_base =
                    st_q.src_line[20:BAS_P8_BASE_LSB]; // [R5]
                st_d.geom.pat_line =
                    st_q.src_line[BAS_P8_LINE_LSB +: 3]; // [R5]
                st_d.geom.pix_off = {1'h0, st_q.src_line[2:0]}; // [R5]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= BAS_ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    chk_src_hi_write: assert property ( // [R2]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && st_q.wstrb0 && wr_idx == BAS_IDX_SRC_HI
        |=> st_q.regs.src_addr[20:16] == $past(st_q.wdata[4:0]))
        else $error("source high byte not stored");

    chk_dst_hi_write: assert property ( // [R7]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && st_q.wstrb0 && wr_idx == BAS_IDX_DST_HI
        |=> st_q.regs.dst_addr[20:16] == $past(st_q.wdata[4:0]))
        else $error("destination high byte not stored");

    chk_off_hi_write: assert property ( // [R8]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && st_q.wstrb0 && wr_idx == BAS_IDX_OFF_HI
        |=> st_q.regs.line_off[10:8] == $past(st_q.wdata[2:0]))
        else $error("offset high bits not stored");

    chk_host_bit0: assert property ( // [R3]
        @(posedge aclk) disable iff (!aresetn)
        $past(st_q.regs.src_host)
        |-> geom.src_line[20:1] == 20'h0
            && geom.src_line[0] == geom.host_byte_sel)
        else $error("host source leaks upper address bits");

    chk_pat_sum: assert property ( // [R4] [R5]
        @(posedge aclk) disable iff (!aresetn)
        st_q.regs.pat_fill && !st_q.regs.src_host && !st_q.regs.bpp16
        |=> {geom.pat_base, geom.pat_line, geom.pix_off[2:0]}
            == $past(st_q.src_line))
        else $error("8 bpp pattern fields do not sum to source");

    chk_pat16_fields: assert property ( // [R6]
        @(posedge aclk) disable iff (!aresetn)
        st_q.regs.pat_fill && !st_q.regs.src_host && st_q.regs.bpp16
        |=> {geom.pat_base[13:0], geom.pat_line, geom.pix_off}
            == $past(st_q.src_line) && !geom.pat_base[14])
        else $error("16 bpp pattern fields wrong");

    chk_width_plus: assert property ( // [R10] [R11]
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn)
        |-> geom.width_pix == {1'h0, $past(st_q.regs.width)} + 11'h1)
        else $error("pixel width is not stored width plus one");

    chk_bpp_follow: assert property ( // [R13]
        @(posedge aclk) disable iff (!aresetn)
        $changed(st_q.regs.bpp16) |=> geom.bpp16 == $past(st_q.regs.bpp16))
        else $error("colour format not passed on");

    chk_load_start: assert property ( // [R14]
        @(posedge aclk) disable iff (!aresetn)
        load_ev |=> st_q.src_line == $past(st_q.regs.src_addr)
            && st_q.dst_line == $past(st_q.regs.dst_addr) ##1
            geom.dst_line == $past(st_q.dst_line))
        else $error("line load did not restart at start");

    chk_rect_step: assert property ( // [R9] [R14]
        @(posedge aclk) disable iff (!aresetn)
        next_ev && !load_ev && !st_q.regs.dst_linear
        |=> st_q.dst_line == $past(st_q.dst_line) + $past(off_bytes))
        else $error("rectangular step missed the offset");

    chk_linear_hold: assert property ( // [R9] [R12]
        @(posedge aclk) disable iff (!aresetn)
        next_ev && !load_ev && st_q.regs.src_linear
            && !st_q.regs.pat_fill
        |=> $stable(st_q.src_line))
        else $error("linear source moved by the offset");

    chk_pat_step: assert property ( // [R4] [R5]
        @(posedge aclk) disable iff (!aresetn)
        next_ev && !load_ev && st_q.regs.pat_fill && !st_q.regs.src_host
            && !st_q.regs.bpp16
        |=> st_q.src_line[BAS_P8_LINE_LSB +: 3]
            == $past(st_q.src_line[BAS_P8_LINE_LSB +: 3]) + 3'h1
            && st_q.src_line[20:BAS_P8_BASE_LSB]
            == $past(st_q.src_line[20:BAS_P8_BASE_LSB]))
        else $error("8 bpp pattern line step wrong");

    chk_host_hold: assert property ( // [R3]
        @(posedge aclk) disable iff (!aresetn)
        next_ev && !load_ev && st_q.regs.src_host
        |=> $stable(st_q.src_line))
        else $error("host source moved on a line step");

    chk_dst_linear_hold: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        next_ev && !load_ev && st_q.regs.dst_linear
        |=> $stable(st_q.dst_line))
        else $error("linear destination moved by the offset");

endmodule : bas_blit_addr

//--- rtl/bas_pkg.sv
package bas_pkg;

    // Bus geometry
    localparam int BAS_AW = 12;
    localparam int BAS_IW = 10;

    // Register indices; byte address is four times the index
    localparam logic [9:0] BAS_IDX_SRC_LO = 10'h104;
    localparam logic [9:0] BAS_IDX_SRC_MID = 10'h105;
    localparam logic [9:0] BAS_IDX_SRC_HI = 10'h106;
    localparam logic [9:0] BAS_IDX_DST_LO = 10'h108;
    localparam logic [9:0] BAS_IDX_DST_MID = 10'h109;
    localparam logic [9:0] BAS_IDX_DST_HI = 10'h10A;
    localparam logic [9:0] BAS_IDX_OFF_LO = 10'h10C;
    localparam logic [9:0] BAS_IDX_OFF_HI = 10'h10D;
    localparam logic [9:0] BAS_IDX_WID_LO = 10'h110;
    localparam logic [9:0] BAS_IDX_WID_HI = 10'h111;
    localparam logic [9:0] BAS_IDX_CTRL = 10'h120;
    localparam logic [9:0] BAS_IDX_CMD = 10'h121;
    localparam logic [9:0] BAS_IDX_SRC_LINE = 10'h124;
    localparam logic [9:0] BAS_IDX_DST_LINE = 10'h125;
    localparam logic [9:0] BAS_IDX_WID_PIX = 10'h126;

    // Control register bit positions
    localparam int BAS_CTRL_BPP16 = 0;
    localparam int BAS_CTRL_SRC_LIN = 1;
    localparam int BAS_CTRL_DST_LIN = 2;
    localparam int BAS_CTRL_SRC_HOST = 3;
    localparam int BAS_CTRL_PAT_FILL = 4;

    // Command register bit positions
    localparam int BAS_CMD_LOAD = 0;
    localparam int BAS_CMD_NEXT = 1;

    // Pattern field low bit positions
    localparam int BAS_P8_LINE_LSB = 3;
    localparam int BAS_P16_LINE_LSB = 4;
    localparam int BAS_P8_BASE_LSB = 6;
    localparam int BAS_P16_BASE_LSB = 7;

    localparam logic [1:0] BAS_RESP_OKAY = 2'h0;
    localparam logic [1:0] BAS_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [20:0] src_addr;
        logic [20:0] dst_addr;
        logic [10:0] line_off;
        logic [9:0] width;
        logic bpp16;
        logic src_linear;
        logic dst_linear;
        logic src_host;
        logic pat_fill;
    } bas_regs_t;

    typedef struct packed {
        logic [20:0] src_line;
        logic [20:0] dst_line;
        logic [10:0] width_pix;
        logic [14:0] pat_base;
        logic [2:0] pat_line;
        logic [3:0] pix_off;
        logic host_byte_sel;
        logic bpp16;
    } bas_geom_t;

    typedef struct packed {
        bas_regs_t regs;
        logic [20:0] src_line;
        logic [20:0] dst_line;
        bas_geom_t geom;
        logic aw_held;
        logic w_held;
        logic [BAS_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bas_state_t;

    localparam bas_state_t BAS_ST_RST = '0;

endpackage : bas_pkg

//--- bench/bas_blit_addr_bench.sv
`timescale 1ns/1ps
module bas_blit_addr_bench;
    import bas_pkg::*;
    logic aclk;
    logic aresetn;
    logic [BAS_AW-1:0] awaddr;
    logic [BAS_AW-1:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic line_load, line_next;
    bas_geom_t geom;
    int err_total;
    int checks;

    bas_blit_addr i_bas_blit_addr (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_load(line_load), .line_next(line_next), .geom(geom)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task end_of_test;
        if (err_total == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task hang(input string name);
        err_total++;
        $display("[ERR] %s expected answer seen timeout", name);
        end_of_test();
    endtask : hang

    task axi_wr(input logic [9:0] idx, input logic [7:0] d,
                output logic [1:0] r);
        int n;
        logic done;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'hFFFFFF, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        r = 2'h3;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("write response");
    endtask : axi_wr

    task axi_rd(input logic [9:0] idx, output logic [31:0] d,
                output logic [1:0] r);
        int n;
        logic done;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("read data");
    endtask : axi_rd

    task wr(input logic [9:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(idx, d, r);
        chk("write resp", {30'h0, r}, {30'h0, BAS_RESP_OKAY});
    endtask : wr

    task rd_chk(input string name, input logic [9:0] idx,
                input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(idx, d, r);
        chk(name, d, exp);
    endtask : rd_chk

    task set21(input logic [9:0] lo, input logic [20:0] v);
        wr(lo, v[7:0]);
        wr(lo + 10'h1, v[15:8]);
        wr(lo + 10'h2, {3'h0, v[20:16]});
    endtask : set21

    // Pulse the engine strobes for one cycle, then let geom catch up
    task pulse(input logic ld, input logic nx);
        @(posedge aclk);
        line_load <= ld;
        line_next <= nx;
        @(posedge aclk);
        line_load <= 1'b0;
        line_next <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
    endtask : pulse

    task rw(input logic [9:0] idx, input logic [7:0] v, input logic [7:0] e);
        rd_chk("reg reset", idx, 32'h0);
        wr(idx, v);
        rd_chk("reg readback", idx, {24'h0, e});
    endtask : rw

    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rw(BAS_IDX_SRC_LO, 8'hA5, 8'hA5);
        rw(BAS_IDX_SRC_MID, 8'h5A, 8'h5A);
        rw(BAS_IDX_SRC_HI, 8'hFF, 8'h1F);
        rw(BAS_IDX_DST_LO, 8'h3C, 8'h3C);
        rw(BAS_IDX_DST_MID, 8'hC3, 8'hC3);
        rw(BAS_IDX_DST_HI, 8'hFF, 8'h1F);
        rw(BAS_IDX_OFF_LO, 8'h34, 8'h34);
        rw(BAS_IDX_OFF_HI, 8'hFF, 8'h07);
        rw(BAS_IDX_WID_LO, 8'h80, 8'h80);
        rw(BAS_IDX_WID_HI, 8'hFF, 8'h03);
        rd_chk("width pixels", BAS_IDX_WID_PIX, 32'h381);
        chk("geom width", 32'(geom.width_pix), 32'h381);
        axi_wr(10'h107, 8'h55, r);
        chk("unmapped bresp", 32'(r), 32'(BAS_RESP_SLVERR));
        axi_rd(10'h107, d, r);
        chk("unmapped rresp", 32'(r), 32'(BAS_RESP_SLVERR));
        chk("unmapped rdata", d, 32'h0);
    endtask : t_regs

    task t_lines;
        wr(BAS_IDX_CTRL, 8'h00);
        set21(BAS_IDX_SRC_LO, 21'h1FFFF0);
        set21(BAS_IDX_DST_LO, 21'h000100);
        wr(BAS_IDX_OFF_LO, 8'h10);
        wr(BAS_IDX_OFF_HI, 8'h00);
        pulse(1'b1, 1'b0);
        chk("src start", 32'(geom.src_line), 32'h1FFFF0);
        chk("dst start", 32'(geom.dst_line), 32'h100);
        chk("bpp8", 32'(geom.bpp16), 32'h0);
        // Word offset 0x10 is a 0x20 byte step; source wraps at 21 bits
        pulse(1'b0, 1'b1);
        chk("src step", 32'(geom.src_line), 32'h10);
        chk("dst step", 32'(geom.dst_line), 32'h120);
        rd_chk("src line reg", BAS_IDX_SRC_LINE, 32'h10);
        pulse(1'b1, 1'b1);
        chk("load wins", 32'(geom.src_line), 32'h1FFFF0);
        wr(BAS_IDX_CTRL, 8'h06);
        pulse(1'b0, 1'b1);
        chk("src linear", 32'(geom.src_line), 32'h1FFFF0);
        chk("dst linear", 32'(geom.dst_line), 32'h100);
        rd_chk("ctrl readback", BAS_IDX_CTRL, 32'h6);
        // Strobes through the command register: step, then restart
        wr(BAS_IDX_CTRL, 8'h00);
        wr(BAS_IDX_CMD, 8'h02);
        rd_chk("cmd next", BAS_IDX_DST_LINE, 32'h120);
        wr(BAS_IDX_CMD, 8'h01);
        rd_chk("cmd load", BAS_IDX_DST_LINE, 32'h100);
        rd_chk("cmd reads zero", BAS_IDX_CMD, 32'h0);
    endtask : t_lines

    task t_host;
        wr(BAS_IDX_CTRL, 8'h08);
        wr(BAS_IDX_SRC_LO, 8'hF1);
        pulse(1'b1, 1'b0);
        chk("host src", 32'(geom.src_line), 32'h1);
        chk("host byte", 32'(geom.host_byte_sel), 32'h1);
        pulse(1'b0, 1'b1);
        chk("host hold", 32'(geom.src_line), 32'h1);
        chk("host base", 32'(geom.pat_base), 32'h0);
        wr(BAS_IDX_SRC_LO, 8'hF0);
        pulse(1'b1, 1'b0);
        chk("host even", 32'(geom.src_line), 32'h0);
        chk("host byte0", 32'(geom.host_byte_sel), 32'h0);
    endtask : t_host

    task t_pat;
        logic [20:0] s;
        logic [20:0] e_base;
        logic [20:0] e_line;
        logic [20:0] e_pix;
        logic [20:0] e_next;
        int b;
        int sh;
        s = 21'h1ABCFD;
        set21(BAS_IDX_SRC_LO, s);
        // Three pixels meets the pattern minimum at both depths
        wr(BAS_IDX_WID_LO, 8'h02);
        wr(BAS_IDX_WID_HI, 8'h00);
        for (b = 0; b < 2; b++) begin
            sh = (b == 1) ? 4 : 3;
            e_base = s >> (sh + 3);
            e_line = (s >> sh) & 21'h7;
            e_pix = s & ((21'h1 << sh) - 21'h1);
            e_next = s & ~(21'h7 << sh);
            wr(BAS_IDX_CTRL, 8'h10 | 8'(b));
            pulse(1'b1, 1'b0);
            chk("pat width", 32'(geom.width_pix), 32'h3);
            chk("pat bpp", 32'(geom.bpp16), 32'(b));
            chk("pat src", 32'(geom.src_line), 32'(s));
            chk("pat base", 32'(geom.pat_base), 32'(e_base));
            chk("pat line", 32'(geom.pat_line), 32'(e_line));
            chk("pat pix", 32'(geom.pix_off), 32'(e_pix));
            // Line field is 7 here, so the step wraps it to 0
            pulse(1'b0, 1'b1);
            chk("pat wrap", 32'(geom.pat_line), 32'h0);
            chk("pat next", 32'(geom.src_line), 32'(e_next));
        end
    endtask : t_pat

    initial begin
        err_total = 0;
        checks = 0;
        aresetn = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        line_load = 1'b0;
        line_next = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
        chk("reset width", 32'(geom.width_pix), 32'h1);
        t_regs();
        t_lines();
        t_host();
        t_pat();
        end_of_test();
    end
endmodule : bas_blit_addr_bench
